/* src/clf_pkg.sv */
// Shared constants of the connection-loss fail-safe block.
package clf_pkg;
    // ========================================================
    // Register indices and address width
    localparam logic [7:0] IDX_STATION_ADDR  = 8'h5c;
    localparam logic [7:0] IDX_LINK_REACTION = 8'h5d;
    localparam logic [7:0] IDX_FS_TARGET     = 8'h5e;
    localparam logic [7:0] IDX_REPEAT_TIME   = 8'h5f;
    localparam logic [7:0] IDX_SAVE_CMD      = 8'h60;
    localparam logic [7:0] IDX_STATUS        = 8'h70;
    localparam int         ADDR_W            = 10;
    // ========================================================
    // Reset values
    localparam logic [15:0] RST_STATION_ADDR  = 16'h0000;
    localparam logic [15:0] RST_LINK_REACTION = 16'h0001;
    localparam logic [31:0] RST_FS_TARGET     = 32'h0000_0000;
    localparam logic [15:0] RST_REPEAT_TIME   = 16'h0000;
    // ========================================================
    // Reaction field positions and codes
    localparam int         LOSS_LSB    = 0;
    localparam int         PWRUP_LSB   = 2;
    localparam int         IOPS_LSB    = 4;
    localparam logic [1:0] ACT_CONT    = 2'h0;
    localparam logic [1:0] ACT_ABORT   = 2'h1;
    localparam logic [1:0] ACT_SAFE    = 2'h2;
    localparam logic [5:0] PWRUP_SEC_1 = 6'h0f;
    localparam logic [5:0] PWRUP_SEC_2 = 6'h1e;
    localparam logic [5:0] PWRUP_SEC_3 = 6'h3c;
    // ========================================================
    // Station name source and text prefix "pse-"
    typedef enum logic [1:0] {
        CLF_SRC_NONE,
        CLF_SRC_SWITCH,
        CLF_SRC_PARAM,
        CLF_SRC_CTRL
    } clf_src_e;
    localparam logic [31:0] NAME_PREFIX = 32'h7073_652d;
    // ========================================================
    // Timing
    localparam longint CLK_PERIOD_NS = 20;
    localparam longint SECOND_NS     = 1000000000;
    localparam int     SEC_CYCLES    = int'(SECOND_NS / CLK_PERIOD_NS);
endpackage

/* src/clf_tick_if.sv */
// One-second tick carried from the divider to the fail-safe logic.
`timescale 1ns/100ps
`default_nettype none
interface clf_tick_if;
    logic tick;
    modport src (output tick);
    modport snk (input tick);
endinterface
`default_nettype wire

/* src/clf_sec_tick.sv */
// Divider producing a one-cycle pulse once per second.
`timescale 1ns/100ps
`default_nettype none
module clf_sec_tick #(
    parameter int CYCLES = 50000000
) (
    // Clock and reset
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    // Tick out
    clf_tick_if.src     tick_if
);
    logic [31:0] cnt_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q        <= 32'h0;
            tick_if.tick <= 1'b0;
        end else if (cnt_q == 32'(CYCLES - 1)) begin
            cnt_q        <= 32'h0;
            tick_if.tick <= 1'b1;
        end else begin
            cnt_q        <= cnt_q + 32'h1;
            tick_if.tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* src/clf_top.sv */
// Station address selection and fail-safe reaction to link faults.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Stored address is used when switches absent or 00 and value nonzero.
// - Address from stored parameter gives name of fixed prefix plus number.
// - Written address becomes active only after save and restart.
// - Switches 00 and stored address zero keep controller-assigned name.
// - Lost link acts on bits 1-0: continue, abort, safe run, reserved.
// - No link after power-up: bits 3-2 pick none, 15, 30, 60 s safe run.
// - Bad provider status acts on bits 5-4 like link loss codes.
// - Every safe run targets the signed safe-position parameter.
// - Failed safe run repeats after repetition period; zero disables.
module clf_top
    import clf_pkg::*;
#(
    parameter int CYCLES_PER_SEC = clf_pkg::SEC_CYCLES
) (
    // Clock and reset
    input  wire logic                       REF_CLK_I,
    input  wire logic                       SYS_RST_I,
    // Avalon-MM slave
    input  wire logic [clf_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
    input  wire logic                       AVS_READ_I,
    input  wire logic                       AVS_WRITE_I,
    input  wire logic [3:0]                 AVS_BYTEENABLE_I,
    input  wire logic [31:0]                AVS_WRITEDATA_I,
    output logic      [31:0]                AVS_READDATA_O,
    output logic                            AVS_WAITREQUEST_O,
    // Address switches and stored address
    input  wire logic                       SWITCH_FITTED_I,
    input  wire logic [7:0]                 SWITCH_ADDR_I,
    input  wire logic [15:0]                STORED_ADDR_I,
    // Effective station identity
    output logic      [15:0]                STATION_ADDR_O,
    output clf_pkg::clf_src_e               NAME_SRC_O,
    output logic      [31:0]                NAME_PREFIX_O,
    output logic                            SAVE_REQ_O,
    output logic      [15:0]                SAVE_ADDR_O,
    // Link and drive status
    input  wire logic                       LINK_UP_I,
    input  wire logic                       IOPS_BAD_I,
    input  wire logic                       RUN_FAILED_I,
    // Drive commands
    output logic                            ABORT_O,
    output logic                            SAFE_RUN_O,
    output logic      [31:0]                SAFE_TARGET_O
);
    import clf_pkg::*;

    // ========================================================
    // Helpers
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] idx);
        return a == {idx, 2'b00};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [5:0] pwrup_delay(input logic [1:0] code);
        case (code)
            2'h1:    return PWRUP_SEC_1;
            2'h2:    return PWRUP_SEC_2;
            default: return PWRUP_SEC_3;
        endcase
    endfunction

    // ========================================================
    // Second tick
    clf_tick_if tick_if ();

    clf_sec_tick #(
        .CYCLES (CYCLES_PER_SEC)
    ) u_tick (
        .clk_i   (REF_CLK_I),
        .rst_i   (SYS_RST_I),
        .tick_if (tick_if)
    );

    // ========================================================
    // Bus slave: one wait cycle, then the access completes.
    logic        req;
    logic        acc;
    logic        wr_acc;
    logic [15:0] addr_q;
    logic [15:0] react_q;
    logic [31:0] target_q;
    logic [15:0] repeat_q;
    logic        link_seen_q;
    logic        pu_done_q;
    logic        rep_arm_q;
    logic [15:0] active_addr_q;

    assign req    = AVS_READ_I | AVS_WRITE_I;
    assign acc    = req & ~AVS_WAITREQUEST_O;
    assign wr_acc = AVS_WRITE_I & ~AVS_WAITREQUEST_O;

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            AVS_WAITREQUEST_O <= 1'b1;
        end else begin
            AVS_WAITREQUEST_O <= ~(req & AVS_WAITREQUEST_O);
        end
    end

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            AVS_READDATA_O <= 32'h0;
        end else if (AVS_READ_I & AVS_WAITREQUEST_O) begin
            if (hit(AVS_ADDRESS_I, IDX_STATION_ADDR)) begin
                AVS_READDATA_O <= {16'h0, addr_q};
            end else if (hit(AVS_ADDRESS_I, IDX_LINK_REACTION)) begin
                AVS_READDATA_O <= {16'h0, react_q};
            end else if (hit(AVS_ADDRESS_I, IDX_FS_TARGET)) begin
                AVS_READDATA_O <= target_q;
            end else if (hit(AVS_ADDRESS_I, IDX_REPEAT_TIME)) begin
                AVS_READDATA_O <= {16'h0, repeat_q};
            end else if (hit(AVS_ADDRESS_I, IDX_STATUS)) begin
                AVS_READDATA_O <= {active_addr_q, 9'h0, NAME_SRC_O,
                                   rep_arm_q, pu_done_q, link_seen_q,
                                   IOPS_BAD_I, LINK_UP_I};
            end else begin
                AVS_READDATA_O <= 32'h0;
            end
        end
    end

    // Writable parameters; the address only reaches the live station
    // address through the save port and a restart.
    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            addr_q   <= RST_STATION_ADDR;
            react_q  <= RST_LINK_REACTION;
            target_q <= RST_FS_TARGET;
            repeat_q <= RST_REPEAT_TIME;
        end else if (wr_acc) begin
            if (hit(AVS_ADDRESS_I, IDX_STATION_ADDR)) begin
                addr_q <= 16'(merge({16'h0, addr_q}, AVS_WRITEDATA_I,
                                    AVS_BYTEENABLE_I));
            end else if (hit(AVS_ADDRESS_I, IDX_LINK_REACTION)) begin
                react_q <= 16'(merge({16'h0, react_q}, AVS_WRITEDATA_I,
                                     AVS_BYTEENABLE_I));
            end else if (hit(AVS_ADDRESS_I, IDX_FS_TARGET)) begin
                target_q <= merge(target_q, AVS_WRITEDATA_I,
                                  AVS_BYTEENABLE_I);
            end else if (hit(AVS_ADDRESS_I, IDX_REPEAT_TIME)) begin
                repeat_q <= 16'(merge({16'h0, repeat_q}, AVS_WRITEDATA_I,
                                      AVS_BYTEENABLE_I));
            end
        end
    end

    // Writing bit 0 of the save command hands the address to storage.
    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            SAVE_REQ_O  <= 1'b0;
            SAVE_ADDR_O <= 16'h0;
        end else begin
            SAVE_REQ_O  <= wr_acc & hit(AVS_ADDRESS_I, IDX_SAVE_CMD)
                           & AVS_BYTEENABLE_I[0] & AVS_WRITEDATA_I[0];
            SAVE_ADDR_O <= addr_q;
        end
    end

    // ========================================================
    // Station address, resolved once in the first cycle after reset.
    logic boot_q;

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            boot_q         <= 1'b0;
            active_addr_q  <= 16'h0;
            STATION_ADDR_O <= 16'h0;
            NAME_SRC_O     <= CLF_SRC_NONE;
            NAME_PREFIX_O  <= 32'h0;
        end else if (!boot_q) begin
            boot_q        <= 1'b1;
            active_addr_q <= STORED_ADDR_I;
            if (SWITCH_FITTED_I && SWITCH_ADDR_I != 8'h00) begin
                STATION_ADDR_O <= {8'h00, SWITCH_ADDR_I};
                NAME_SRC_O     <= CLF_SRC_SWITCH;
            end else if (STORED_ADDR_I != 16'h0) begin
                STATION_ADDR_O <= STORED_ADDR_I;
                NAME_SRC_O     <= CLF_SRC_PARAM;
                NAME_PREFIX_O  <= NAME_PREFIX;
            end else begin
                STATION_ADDR_O <= 16'h0;
                NAME_SRC_O     <= CLF_SRC_CTRL;
            end
        end
    end

    // ========================================================
    // Fault events
    logic       link_prev_q;
    logic       iops_prev_q;
    logic       loss_ev;
    logic       iops_ev;
    logic [1:0] loss_code;
    logic [1:0] pu_code;
    logic [1:0] iops_code;

    assign loss_code = react_q[LOSS_LSB +: 2];
    assign pu_code   = react_q[PWRUP_LSB +: 2];
    assign iops_code = react_q[IOPS_LSB +: 2];
    assign loss_ev   = link_seen_q & link_prev_q & ~LINK_UP_I;
    assign iops_ev   = IOPS_BAD_I & ~iops_prev_q;

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            link_prev_q <= 1'b0;
            iops_prev_q <= 1'b0;
            link_seen_q <= 1'b0;
        end else begin
            link_prev_q <= LINK_UP_I;
            iops_prev_q <= IOPS_BAD_I;
            if (LINK_UP_I) begin
                link_seen_q <= 1'b1;
            end
        end
    end

    // Power-up wait for the first link.
    logic [5:0] pu_sec_q;
    logic       pu_fire;

    assign pu_fire = ~pu_done_q & ~link_seen_q & ~LINK_UP_I
                     & (pu_code != 2'h0)
                     & (pu_sec_q == pwrup_delay(pu_code));

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            pu_sec_q  <= 6'h0;
            pu_done_q <= 1'b0;
        end else if (LINK_UP_I || link_seen_q) begin
            pu_done_q <= 1'b1;
        end else if (pu_fire) begin
            pu_done_q <= 1'b1;
        end else if (tick_if.tick && !pu_done_q && pu_sec_q != 6'h3f) begin
            pu_sec_q <= pu_sec_q + 6'h1;
        end
    end

    // Repetition of a failed safe run.
    logic [15:0] rep_sec_q;
    logic        rep_fire;

    assign rep_fire = rep_arm_q & (rep_sec_q == repeat_q);

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            rep_arm_q <= 1'b0;
            rep_sec_q <= 16'h0;
        end else if (RUN_FAILED_I && repeat_q != 16'h0) begin
            rep_arm_q <= 1'b1;
            rep_sec_q <= 16'h0;
        end else if (rep_fire || repeat_q == 16'h0) begin
            rep_arm_q <= 1'b0;
        end else if (rep_arm_q && tick_if.tick) begin
            rep_sec_q <= rep_sec_q + 16'h1;
        end
    end

    // ========================================================
    // Drive commands
    logic safe_req;
    logic abort_req;

    assign safe_req  = (loss_ev & (loss_code == ACT_SAFE))
                     | (iops_ev & (iops_code == ACT_SAFE))
                     | pu_fire | rep_fire;
    assign abort_req = (loss_ev & (loss_code == ACT_ABORT))
                     | (iops_ev & (iops_code == ACT_ABORT));

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ABORT_O       <= 1'b0;
            SAFE_RUN_O    <= 1'b0;
            SAFE_TARGET_O <= 32'h0;
        end else begin
            ABORT_O    <= abort_req;
            SAFE_RUN_O <= safe_req;
            if (safe_req) begin
                SAFE_TARGET_O <= target_q;
            end
        end
    end

    // ========================================================
    // Checks
    sequence s_req_waits;
        req && AVS_WAITREQUEST_O;
    endsequence

    sequence s_link_lost;
        link_seen_q && link_prev_q && !LINK_UP_I;
    endsequence

    a_bus_one_wait: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I) s_req_waits |=> !AVS_WAITREQUEST_O ##1
        AVS_WAITREQUEST_O)
        else $error("Bus access did not complete after one wait.");

    a_loss_abort: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        s_link_lost and (loss_code == ACT_ABORT) |=> ABORT_O && !SAFE_RUN_O)
        else $error("Link loss with abort code gave no abort.");

    a_loss_safe: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        s_link_lost and (loss_code == ACT_SAFE) |=> SAFE_RUN_O)
        else $error("Link loss with safe code gave no safe run.");

    a_iops_react: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        $rose(IOPS_BAD_I) && iops_code == ACT_CONT && !loss_ev
        && !pu_fire && !rep_fire |=> !SAFE_RUN_O && !ABORT_O)
        else $error("Continue code on bad provider status caused action.");

    a_safe_target: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        SAFE_RUN_O |-> SAFE_TARGET_O == $past(target_q))
        else $error("Safe run target differs from safe position.");

    a_pwrup_delay: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        pu_fire |-> pu_sec_q == pwrup_delay(pu_code) && pu_code != 2'h0
        ##1 SAFE_RUN_O)
        else $error("Power-up safe run at wrong second count.");

    a_pwrup_cancel: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        LINK_UP_I |=> pu_done_q && !pu_fire)
        else $error("Power-up safe run still pending after link up.");

    a_addr_param: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        !SYS_RST_I && !boot_q && !(SWITCH_FITTED_I && SWITCH_ADDR_I != 8'h00)
        && STORED_ADDR_I != 16'h0 |=> STATION_ADDR_O == $past(STORED_ADDR_I)
        && NAME_SRC_O == CLF_SRC_PARAM && NAME_PREFIX_O == NAME_PREFIX)
        else $error("Stored address not taken as station address.");

    a_addr_late: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        boot_q |=> $stable(STATION_ADDR_O) && $stable(active_addr_q))
        else $error("Station address changed without restart.");

    a_repeat_off: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        repeat_q == 16'h0 && !(RUN_FAILED_I && repeat_q != 16'h0)
        |=> !rep_arm_q)
        else $error("Repetition armed with zero period.");
endmodule
`default_nettype wire

/* test/clf_ctrl_model.sv */
// Behavioural fieldbus IO controller driving link and provider status.
`timescale 1ns/100ps
`default_nettype none
module clf_ctrl_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Commands from the bench
    input  wire logic       connect_i,
    input  wire logic       cpu_stop_i,
    input  wire logic [7:0] setup_i,
    // Status seen by the drive
    output logic            link_up_o,
    output logic            iops_bad_o
);
    logic [7:0] wait_q;

    // The link comes up only after the setup delay and drops at once.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i || !connect_i) begin
            wait_q    <= 8'h00;
            link_up_o <= 1'b0;
        end else if (wait_q >= setup_i) begin
            link_up_o <= 1'b1;
        end else begin
            wait_q <= wait_q + 8'h01;
        end
    end

    // Provider status can only be reported bad over a running link.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            iops_bad_o <= 1'b0;
        end else begin
            iops_bad_o <= cpu_stop_i & link_up_o;
        end
    end
endmodule
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the connection-loss fail-safe block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import clf_pkg::*;
    // ========================================================
    // Signals
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, fitted = 1'b0;
    logic connect = 1'b0, cpu_stop = 1'b0, run_failed = 1'b0;
    logic              link_up, iops_bad, wreq, save_req, abort_p, safe_p;
    logic [ADDR_W-1:0] addr = '0;
    logic [3:0]        be = 4'hf;
    logic [7:0]        sw = 8'h00, setup = 8'h00;
    logic [15:0]       stored = 16'h0000, st_addr, save_addr, ea;
    logic [31:0]       wdata = 32'h0, rdata, prefix, tgt_o, target, d, v;
    logic [1:0]        es;
    clf_src_e          src;
    int                seed, error_cnt, tests_run, cyc, i, n, ns, na, nv;
    int                secs [4] = '{0, 15, 30, 60};
    logic [7:0]        ridx [3] = '{8'h5c, 8'h5d, 8'h5e};
    logic [31:0]       rrst [3] = '{32'h0, 32'h1, 32'h0};
    logic [31:0]       rmsk [3] = '{32'h0000_ffff, 32'h0000_ffff, '1};
    logic [24:0]       bcase [4] = '{{1'b0, 8'h5a, 16'h0005},
        {1'b1, 8'h00, 16'h0123}, {1'b1, 8'h12, 16'h0040}, 25'h0ff_ffff & 0};

    always #10 clk = ~clk;

    clf_top #(.CYCLES_PER_SEC(10)) u_clf_top (
        .REF_CLK_I         (clk),
        .SYS_RST_I         (rst),
        .AVS_ADDRESS_I     (addr),
        .AVS_READ_I        (rd),
        .AVS_WRITE_I       (wr),
        .AVS_BYTEENABLE_I  (be),
        .AVS_WRITEDATA_I   (wdata),
        .AVS_READDATA_O    (rdata),
        .AVS_WAITREQUEST_O (wreq),
        .SWITCH_FITTED_I   (fitted),
        .SWITCH_ADDR_I     (sw),
        .STORED_ADDR_I     (stored),
        .STATION_ADDR_O    (st_addr),
        .NAME_SRC_O        (src),
        .NAME_PREFIX_O     (prefix),
        .SAVE_REQ_O        (save_req),
        .SAVE_ADDR_O       (save_addr),
        .LINK_UP_I         (link_up),
        .IOPS_BAD_I        (iops_bad),
        .RUN_FAILED_I      (run_failed),
        .ABORT_O           (abort_p),
        .SAFE_RUN_O        (safe_p),
        .SAFE_TARGET_O     (tgt_o)
    );

    clf_ctrl_model u_clf_ctrl_model (
        .clk_i      (clk),
        .rst_i      (rst),
        .connect_i  (connect),
        .cpu_stop_i (cpu_stop),
        .setup_i    (setup),
        .link_up_o  (link_up),
        .iops_bad_o (iops_bad)
    );

    // ========================================================
    // Expectations
    function automatic logic [1:0] exp_src(input logic [24:0] c);
        if (c[24] && c[23:16] != 8'h00) return CLF_SRC_SWITCH;
        if (c[15:0] != 16'h0000) return CLF_SRC_PARAM;
        return CLF_SRC_CTRL;
    endfunction

    function automatic logic [15:0] exp_addr(input logic [24:0] c);
        if (c[24] && c[23:16] != 8'h00) return {8'h00, c[23:16]};
        return c[15:0];
    endfunction

    // ========================================================
    // Tasks
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // A request stays up until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] rdv);
        @(posedge clk);
        rd    <= !w;
        wr    <= w;
        addr  <= {idx, 2'b00};
        wdata <= wd;
        do @(posedge clk); while (wreq !== 1'b0);
        rdv = rdata;
        rd  <= 1'b0;
        wr  <= 1'b0;
    endtask

    task automatic boot(input logic [24:0] c);
        fitted  <= c[24];
        sw      <= c[23:16];
        stored  <= c[15:0];
        connect <= 1'b0;
        rst     <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic watch(input int cycles);
        ns = 0;
        na = 0;
        nv = 0;
        repeat (cycles) begin
            @(posedge clk);
            ns += int'(safe_p === 1'b1);
            na += int'(abort_p === 1'b1);
            nv += int'(save_req === 1'b1);
        end
    endtask

    task automatic wait_safe(input int lim);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (safe_p !== 1'b1 && n < lim);
    endtask

    task automatic pulse_fail();
        run_failed <= 1'b1;
        @(posedge clk);
        run_failed <= 1'b0;
    endtask

    // ========================================================
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // ========================================================
    // Main sequence
    initial begin
        seed = 10156;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 3; i++) begin
            bus(1'b0, ridx[i], 32'h0, d);
            chk("reg reset", d, rrst[i]);
            v = $random(seed);
            bus(1'b1, ridx[i], v, d);
            bus(1'b0, ridx[i], 32'h0, d);
            chk("reg readback", d, v & rmsk[i]);
        end
        bus(1'b0, 8'h40, 32'h0, d);
        chk("unmapped read", d, 32'h0);
        chk("address held", {16'h0, st_addr}, 32'h0);
        $display("test registers finished");
        for (i = 0; i < 8; i++) begin
            v = (i < 4) ? {7'h0, bcase[i]} : $random(seed);
            boot(v[24:0]);
            es = exp_src(v[24:0]);
            ea = exp_addr(v[24:0]);
            chk("name source", {30'h0, src}, {30'h0, es});
            chk("station addr", {16'h0, st_addr}, {16'h0, ea});
            v = (es == CLF_SRC_PARAM) ? NAME_PREFIX : 32'h0;
            chk("name prefix", prefix, v);
        end
        v = {16'h0, 16'($random(seed)) | 16'h0001};
        bus(1'b1, IDX_STATION_ADDR, v, d);
        bus(1'b1, IDX_SAVE_CMD, 32'h1, d);
        watch(4);
        chk("address held", {16'h0, st_addr}, {16'h0, ea});
        chk("save pulses", nv, 1);
        chk("save value", {16'h0, save_addr}, v);
        boot({9'h000, v[15:0]});
        chk("restart addr", {16'h0, st_addr}, v);
        bus(1'b0, IDX_STATUS, 32'h0, d);
        chk("status word", d, {v[15:0], 9'h0, 2'(CLF_SRC_PARAM), 5'h00});
        $display("test address finished");
        for (i = 0; i < 8; i++) begin
            target = $random(seed);
            bus(1'b1, IDX_FS_TARGET, target, d);
            bus(1'b1, IDX_LINK_REACTION, (i & 3) << (i < 4 ? 0 : 4), d);
            setup   <= 8'($random(seed)) & 8'h07;
            connect <= 1'b1;
            repeat (12) @(posedge clk);
            if (i < 4) connect <= 1'b0;
            else cpu_stop <= 1'b1;
            watch(4);
            chk("abort pulses", na, (i & 3) == 1);
            chk("safe run pulses", ns, (i & 3) == 2);
            if ((i & 3) == 2) chk("safe target", tgt_o, target);
            cpu_stop <= 1'b0;
            repeat (3) @(posedge clk);
        end
        $display("test link faults finished");
        bus(1'b1, IDX_REPEAT_TIME, 32'h2, d);
        pulse_fail();
        wait_safe(60);
        chk("repeat delay", n >= 9 && n <= 25, 1);
        chk("repeat target", tgt_o, target);
        bus(1'b1, IDX_REPEAT_TIME, 32'h0, d);
        pulse_fail();
        watch(60);
        chk("repeat disabled", ns, 0);
        $display("test repetition finished");
        for (i = 0; i < 5; i++) begin
            boot(25'h0);
            target = $random(seed);
            bus(1'b1, IDX_FS_TARGET, target, d);
            bus(1'b1, IDX_LINK_REACTION, (i == 4 ? 1 : i) << 2, d);
            if (i == 4) connect <= 1'b1;
            wait_safe(700);
            chk("power-up run", safe_p === 1'b1, i % 4 != 0);
            if (i % 4 != 0) begin
                v = secs[i] * 10;
                chk("power-up delay", n + 8 >= v - 10 && n + 8 <= v + 15, 1);
                chk("power-up target", tgt_o, target);
            end
        end
        $display("test power-up finished");
        tally_and_finish();
    end
endmodule
`default_nettype wire
